/* File: sim/host_irq_model.sv */
// host side of the interrupt pin: external pull-up on an open-drain line
// assumes the block raises irq_n_oe while it pulls the line low
`timescale 1ns/1ps
`default_nettype none
module host_irq_model (
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  output logic irq_line
);
  assign irq_line = irq_n_oe ? irq_n_out : 1'b1;
endmodule : host_irq_model
`default_nettype wire

/* File: sim/line_rx_alarm_interrupt_bench.sv */
// bench for the receive alarm block, two channels, register tasks
// assumes the host model pulls the interrupt line up when released
`timescale 1ns/1ps
`default_nettype none
module line_rx_alarm_interrupt_bench;
  import line_rx_alarm_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [9:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [1:0] lc = '0, mk = '0, on = '0, pr = '0, lp = '0, ff = '0;
  logic [11:0] at = '0, cl = '0;
  logic [1:0] rck, rdt, slc;
  logic [6:0] pct;
  logic es, irq_n_out, irq_n_oe, irq_line, p;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int k, tg;
  int gn[4] = '{15, 29, 36, 45};
  int da[4] = '{8, 9, 7, 6};
  logic [6:0] tb[4] = '{7'h32, 7'h2D, 7'h37, 7'h44};
  always #2 ref_clk = ~ref_clk;
  line_rx_alarm_interrupt #(.NUM_CH(2)) i_dut (.ref_clk, .reset,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .line_clk_pin(lc), .line_mark_pin(mk), .attenuation_db(at),
    .cable_loss_value(cl), .all_ones_alarm(on),
    .pseudo_random_pattern_detect(pr), .loop_code_detect(lp),
    .fifo_limit_status(ff), .rec_clk(rck), .rec_data(rdt),
    .slicer_level_select(slc), .slicer_level_pct(pct),
    .recovered_clock_edge_select(es), .irq_n_out, .irq_n_oe);
  host_irq_model i_host (.irq_n_out, .irq_n_oe, .irq_line);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [9:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask : rc
  task automatic ci(input logic e);
    repeat (3) @(posedge ref_clk);
    #1 chk(irq_line, e);
  endtask : ci
  // line clock pulses, two core cycles high and three core cycles low
  task automatic pz(input int n);
    repeat (n) begin
      @(posedge ref_clk) lc[0] <= 1'b1;
      repeat (2) @(posedge ref_clk);
      lc[0] <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
    repeat (6) @(posedge ref_clk);
  endtask : pz
  task automatic mark_edge();
    @(posedge ref_clk) mk[0] <= 1'b1;
    pz(1);
    mk[0] <= 1'b0;
  endtask : mark_edge
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    rc(OFS_GLOBAL_CTRL, 32'hF, 32'h0);
    rc(OFS_CABLE_THRESH, 32'h3F, 32'h3F);
    rc(OFS_LOS_COUNT, 32'hFFFF, 32'hFFAF);
    rc(10'h100, 32'h8, 32'h0);
    rc(10'h3F0, 32'hFFFFFFFF, 32'h0);
    $display("test reset done");
    for (k = 0; k < 4; k++) begin
      wr(OFS_GLOBAL_CTRL, (32'(k) << 2) | 32'h2);
      #1 chk({22'h0, pct, slc, es}, {22'h0, tb[k], 2'(k), 1'b1});
    end
    // data taken on the chosen edge only; mark flips between edges
    for (k = 0; k < 2; k++) begin
      wr(OFS_GLOBAL_CTRL, 32'(k) << 1);
      @(posedge ref_clk) mk[0] <= 1'b1;
      repeat (3) @(posedge ref_clk);
      lc[0] <= 1'b1;
      repeat (6) @(posedge ref_clk);
      mk[0] <= 1'b0;
      repeat (3) @(posedge ref_clk);
      lc[0] <= 1'b0;
      repeat (6) @(posedge ref_clk);
      #1 chk(rdt[0], !k);
    end
    $display("test slicer and edge done");
    wr(OFS_CABLE_THRESH, 32'h10);
    wr(10'h104, 32'h1);
    wr(OFS_GLOBAL_CTRL, 32'h1);
    @(posedge ref_clk) cl[5:0] <= 6'h10;
    ci(1'b0);
    rc(10'h100, 32'h3F000000, 32'h10000000);
    rc(OFS_CHAN_PENDING, 32'h3, 32'h1);
    rc(10'h108, 32'h3F, 32'h1);
    ci(1'b1);
    rc(10'h108, 32'h3F, 32'h0);
    wr(OFS_CABLE_THRESH, 32'h11);
    ci(1'b0);
    rc(10'h108, 32'h3F, 32'h1);
    $display("test cable flag done");
    for (k = 2; k < 6; k++) begin
      wr(10'h104, 32'h1 << k);
      wr(OFS_GLOBAL_CTRL, 32'h0);
      @(posedge ref_clk) {ff[0], lp[0], pr[0], on[0]} <= 4'(1 << (k - 2));
      ci(1'b1);
      wr(OFS_GLOBAL_CTRL, 32'h1);
      #1 chk(irq_line, 1'b0);
      rc(10'h108, 32'h3F, 32'h1 << k);
      wr(10'h104, 32'h0);
      @(posedge ref_clk) {ff[0], lp[0], pr[0], on[0]} <= 4'h0;
      ci(1'b1);
      rc(10'h108, 32'h3F, 32'h1 << k);
    end
    wr(10'h114, 32'h4);
    @(posedge ref_clk) on[1] <= 1'b1;
    ci(1'b0);
    rc(OFS_CHAN_PENDING, 32'h3, 32'h2);
    rc(10'h118, 32'h3F, 32'h4);
    @(posedge ref_clk) on[1] <= 1'b0;
    ci(1'b0);
    wr(10'h11C, 32'h4);
    ci(1'b1);
    rc(10'h118, 32'h3F, 32'h0);
    rc(10'h11C, 32'hFFFFFFFF, 32'h0);
    $display("test alarm masks done");
    // e1 count below the floor must still need ten intervals
    wr(OFS_LOS_COUNT, 32'h0564);
    for (k = 0; k < 3; k++) begin
      wr(10'h100, k == 2 ? 32'h8 : 32'(k) << 2);
      mark_edge();
      tg = k == 2 ? 4096 : (k ? 10 : 100);
      pz(tg - 1);
      rc(10'h100, 32'h20000, 32'h0);
      pz(1);
      rc(10'h100, 32'h20000, 32'h20000);
    end
    tg = 0;
    repeat (400) begin
      @(posedge ref_clk);
      #1;
      tg += int'(rck[0] !== p);
      p = rck[0];
    end
    chk(tg >= 3, 1'b1);
    mark_edge();
    $display("test digital loss done");
    for (k = 0; k < 4; k++) begin
      wr(10'h100, 32'(k));
      foreach (da[j]) begin
        @(posedge ref_clk) at[5:0] <= 6'(gn[k] + da[j]);
        repeat (4) @(posedge ref_clk);
        rc(10'h100, 32'h20000, (j % 3) ? 32'h20000 : 32'h0);
      end
    end
    $display("test analog loss done");
    tally_and_finish();
  end
endmodule : line_rx_alarm_interrupt_bench
`default_nettype wire

/* File: verilog/chan_if.sv */
// per-channel configuration and loss-of-signal results
// assumes the controller drives the settings and the channel the results
`timescale 1ns/1ps
`default_nettype none
interface chan_if;
  logic [1:0] gain_sel;
  logic e1_mode;
  logic ext_los;
  logic edge_sel;
  logic [7:0] t1_count;
  logic [7:0] e1_count;
  logic digital_los;
  logic analog_los;
  modport ctrl (output gain_sel, e1_mode, ext_los, edge_sel, t1_count,
                e1_count, input digital_los, analog_los);
  modport unit (input gain_sel, e1_mode, ext_los, edge_sel, t1_count,
                e1_count, output digital_los, analog_los);
endinterface : chan_if
`default_nettype wire

/* File: verilog/line_rx_alarm_interrupt.sv */
// receive alarm detection, sticky status and interrupt for NUM_CH channels
// assumes the other alarm detectors run on ref_clk; line pins are async;
// the interrupt pin is open drain with an external pull-up
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - threshold at or below loss raises interrupt
// - loss value is six bits, 1 dB steps
// - slicer code maps to 50/45/55/68 percent
// - data changes on chosen recovered clock edge
// - recovered clock runs from master on loss
// - six alarms, each with its own mask
// - global enable gates every interrupt
// - unmasked alarm change pulls interrupt low
// - status read releases the interrupt line
// - status registers clear when read
// - channel indications merge under global enable
// - t1 loss after programmed run of zeros
// - e1 loss after 10 to 255 zeros
// - analog loss 9 dB below, 3 dB hysteresis
// - analog levels follow equalizer gain setting
// - extended option needs 4096 zeros
// - extended option off after reset
module line_rx_alarm_interrupt
  import line_rx_alarm_pkg::*;
#(
  parameter int NUM_CH = 14
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [NUM_CH-1:0] line_clk_pin,
  input wire logic [NUM_CH-1:0] line_mark_pin,
  input wire logic [6*NUM_CH-1:0] attenuation_db,
  input wire logic [6*NUM_CH-1:0] cable_loss_value,
  input wire logic [NUM_CH-1:0] all_ones_alarm,
  input wire logic [NUM_CH-1:0] pseudo_random_pattern_detect,
  input wire logic [NUM_CH-1:0] loop_code_detect,
  input wire logic [NUM_CH-1:0] fifo_limit_status,
  output logic [NUM_CH-1:0] rec_clk,
  output logic [NUM_CH-1:0] rec_data,
  output logic [1:0] slicer_level_select,
  output logic [6:0] slicer_level_pct,
  output logic recovered_clock_edge_select,
  output logic irq_n_out,
  output logic irq_n_oe
);

  // ----------------------------------------------------------------------
  // global registers
  // ----------------------------------------------------------------------
  logic irq_en_q, irq_en_d, edge_q, edge_d;
  logic [1:0] slice_q, slice_d;
  logic [5:0] thr_q, thr_d;
  logic [7:0] t1_cnt_q, t1_cnt_d, e1_cnt_q, e1_cnt_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] div_q, div_d;
  logic master_tick;

  // ----------------------------------------------------------------------
  // per-channel state
  // ----------------------------------------------------------------------
  logic [1:0] gain_q [NUM_CH], gain_d [NUM_CH];
  logic [NUM_CH-1:0] e1_q, e1_d, ext_q, ext_d;
  alarm_vec_t en_q [NUM_CH], en_d [NUM_CH];
  alarm_vec_t status_q [NUM_CH], status_d [NUM_CH];
  alarm_vec_t prev_q [NUM_CH], prev_d [NUM_CH];
  alarm_vec_t live [NUM_CH], change [NUM_CH], clr [NUM_CH];
  logic [NUM_CH-1:0] pending, dlos, alos;
  logic chg_any;

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  logic [3:0] ch_sel;
  logic ch_ok;
  logic [3:0] ch_reg;

  assign ch_sel = reg_addr[7:4];
  assign ch_reg = reg_addr[3:0];
  assign ch_ok = (reg_addr[9:8] == CH_BASE_SEL) && (int'(ch_sel) < NUM_CH);

  // ----------------------------------------------------------------------
  // master clock divider for the free-running recovered clock
  // ----------------------------------------------------------------------
  always_comb begin
    master_tick = (div_q == 16'(MASTER_HALF_CYC - 1));
    div_d = master_tick ? 16'h0000 : div_q + 16'h0001;
  end

  // ----------------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      chan_if cif ();
      assign cif.gain_sel = gain_q[g];
      assign cif.e1_mode = e1_q[g];
      assign cif.ext_los = ext_q[g];
      assign cif.edge_sel = edge_q;
      assign cif.t1_count = t1_cnt_q;
      assign cif.e1_count = e1_cnt_q;
      assign dlos[g] = cif.digital_los;
      assign alos[g] = cif.analog_los;

      rx_channel_los u_ch (
        .ref_clk(ref_clk),
        .reset(reset),
        .cfg(cif.unit),
        .line_clk_pin(line_clk_pin[g]),
        .line_mark_pin(line_mark_pin[g]),
        .attenuation_db(attenuation_db[6*g +: 6]),
        .master_tick(master_tick),
        .rec_clk(rec_clk[g]),
        .rec_data(rec_data[g])
      );

      always_comb begin
        live[g][ALM_CABLE] = (thr_q <= cable_loss_value[6*g +: 6]);
        live[g][ALM_LOS] = dlos[g] | alos[g];
        live[g][ALM_ONES] = all_ones_alarm[g];
        live[g][ALM_PRBS] = pseudo_random_pattern_detect[g];
        live[g][ALM_LOOP] = loop_code_detect[g];
        live[g][ALM_FIFO] = fifo_limit_status[g];
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // register writes and status next values
  // ----------------------------------------------------------------------
  always_comb begin
    irq_en_d = irq_en_q;
    edge_d = edge_q;
    slice_d = slice_q;
    thr_d = thr_q;
    t1_cnt_d = t1_cnt_q;
    e1_cnt_d = e1_cnt_q;
    e1_d = e1_q;
    ext_d = ext_q;
    chg_any = 1'b0;
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_GLOBAL_CTRL: begin
          irq_en_d = reg_wdata[GCTL_IRQ_EN];
          edge_d = reg_wdata[GCTL_EDGE];
          slice_d = reg_wdata[GCTL_SLICE_LSB +: 2];
        end
        OFS_CABLE_THRESH: begin
          thr_d = reg_wdata[5:0];
        end
        OFS_LOS_COUNT: begin
          t1_cnt_d = reg_wdata[7:0];
          e1_cnt_d = reg_wdata[LOSC_E1_LSB +: 8];
        end
        default: begin
        end
      endcase
    end
    for (int c = 0; c < NUM_CH; c++) begin
      gain_d[c] = gain_q[c];
      en_d[c] = en_q[c];
      clr[c] = '0;
      if (reg_wr && ch_ok && int'(ch_sel) == c) begin
        if (ch_reg == CH_OFS_CTRL) begin
          gain_d[c] = reg_wdata[1:0];
          e1_d[c] = reg_wdata[CHCTL_E1];
          ext_d[c] = reg_wdata[CHCTL_EXT];
        end
        if (ch_reg == CH_OFS_ENABLE) begin
          en_d[c] = reg_wdata[NUM_ALARMS-1:0];
        end
        if (ch_reg == CH_OFS_CLEAR) begin
          clr[c] = reg_wdata[NUM_ALARMS-1:0];
        end
      end
      if (reg_rd && ch_ok && int'(ch_sel) == c && ch_reg == CH_OFS_STATUS) begin
        clr[c] = '1;
      end
      change[c] = live[c] ^ prev_q[c];
      prev_d[c] = live[c];
      // a change in the clearing cycle survives the clear
      status_d[c] = (status_q[c] & ~clr[c]) | change[c];
      chg_any = chg_any | (|change[c]);
      pending[c] = |(status_q[c] & en_q[c]);
    end
  end

  // ----------------------------------------------------------------------
  // read mux: data appear in the cycle after the strobe
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == OFS_GLOBAL_CTRL) begin
        rdata_d[GCTL_IRQ_EN] = irq_en_q;
        rdata_d[GCTL_EDGE] = edge_q;
        rdata_d[GCTL_SLICE_LSB +: 2] = slice_q;
      end else if (reg_addr == OFS_CABLE_THRESH) begin
        rdata_d[5:0] = thr_q;
      end else if (reg_addr == OFS_LOS_COUNT) begin
        rdata_d[7:0] = t1_cnt_q;
        rdata_d[LOSC_E1_LSB +: 8] = e1_cnt_q;
      end else if (reg_addr == OFS_CHAN_PENDING) begin
        rdata_d[NUM_CH-1:0] = pending;
      end else if (ch_ok) begin
        for (int c = 0; c < NUM_CH; c++) begin
          if (int'(ch_sel) == c) begin
            if (ch_reg == CH_OFS_CTRL) begin
              rdata_d[1:0] = gain_q[c];
              rdata_d[CHCTL_E1] = e1_q[c];
              rdata_d[CHCTL_EXT] = ext_q[c];
              rdata_d[CHCTL_LIVE_LSB +: NUM_ALARMS] = live[c];
              rdata_d[CHCTL_CLV_LSB +: 6] = cable_loss_value[6*c +: 6];
            end else if (ch_reg == CH_OFS_ENABLE) begin
              rdata_d[NUM_ALARMS-1:0] = en_q[c];
            end else if (ch_reg == CH_OFS_STATUS) begin
              rdata_d[NUM_ALARMS-1:0] = status_q[c];
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_en_q <= 1'b0;
      edge_q <= 1'b0;
      slice_q <= 2'h0;
      thr_q <= 6'h3F;
      t1_cnt_q <= T1_LOS_RESET;
      e1_cnt_q <= E1_LOS_RESET;
      rdata_q <= 32'h0000_0000;
      div_q <= 16'h0000;
      e1_q <= '0;
      ext_q <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        gain_q[c] <= 2'h0;
        en_q[c] <= '0;
        status_q[c] <= '0;
        prev_q[c] <= '0;
      end
    end else begin
      irq_en_q <= irq_en_d;
      edge_q <= edge_d;
      slice_q <= slice_d;
      thr_q <= thr_d;
      t1_cnt_q <= t1_cnt_d;
      e1_cnt_q <= e1_cnt_d;
      rdata_q <= rdata_d;
      div_q <= div_d;
      e1_q <= e1_d;
      ext_q <= ext_d;
      for (int c = 0; c < NUM_CH; c++) begin
        gain_q[c] <= gain_d[c];
        en_q[c] <= en_d[c];
        status_q[c] <= status_d[c];
        prev_q[c] <= prev_d[c];
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign reg_rdata = rdata_q;
  assign slicer_level_select = slice_q;
  assign slicer_level_pct = SLICER_PCT[slice_q];
  assign recovered_clock_edge_select = edge_q;
  assign irq_n_oe = irq_en_q & (|pending);
  // pin only ever sinks current; the pull-up makes the high level
  assign irq_n_out = 1'b0;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_change_latches;
    @(posedge ref_clk) disable iff (reset)
    |change[0] |=> (status_q[0] & $past(change[0])) == $past(change[0]);
  endproperty
  a_change_latches: assert property (p_change_latches)
    else $error("alarm change not latched");

  property p_enable_gate;
    @(posedge ref_clk) disable iff (reset)
    !irq_en_q |-> !irq_n_oe;
  endproperty
  a_enable_gate: assert property (p_enable_gate)
    else $error("interrupt without global enable");

  property p_irq_pull;
    @(posedge ref_clk) disable iff (reset)
    irq_en_q && |(status_q[0] & en_q[0]) |-> irq_n_oe;
  endproperty
  a_irq_pull: assert property (p_irq_pull)
    else $error("unmasked status did not pull interrupt");

  property p_read_clears;
    @(posedge ref_clk) disable iff (reset)
    reg_rd && reg_addr == {CH_BASE_SEL, 4'h0, CH_OFS_STATUS}
      && !(|change[0]) |=> status_q[0] == '0;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status not cleared by read");

  property p_read_releases;
    @(posedge ref_clk) disable iff (reset)
    reg_rd && reg_addr == {CH_BASE_SEL, 4'h0, CH_OFS_STATUS}
      && pending == NUM_CH'(1) && !chg_any |=> !irq_n_oe;
  endproperty
  a_read_releases: assert property (p_read_releases)
    else $error("interrupt held after status read");

  property p_slicer_write;
    @(posedge ref_clk) disable iff (reset)
    reg_wr && reg_addr == OFS_GLOBAL_CTRL |=>
      slicer_level_select == $past(reg_wdata[3:2])
      && slicer_level_pct == SLICER_PCT[$past(reg_wdata[3:2])];
  endproperty
  a_slicer_write: assert property (p_slicer_write)
    else $error("slicer setting not applied");

  property p_pending_tree;
    @(posedge ref_clk) disable iff (reset)
    irq_n_oe |-> irq_en_q && pending != '0;
  endproperty
  a_pending_tree: assert property (p_pending_tree)
    else $error("interrupt without channel indication");

  property p_ext_reset;
    @(posedge ref_clk)
    $past(reset) |-> ext_q == '0;
  endproperty
  a_ext_reset: assert property (p_ext_reset)
    else $error("extended option on after reset");

  property p_rdata_cycle;
    @(posedge ref_clk) disable iff (reset)
    reg_rd && reg_addr == OFS_CABLE_THRESH |=>
      reg_rdata == {26'h0, $past(thr_q)} ##1 reg_rdata == 32'h0 || $past(reg_rd);
  endproperty
  a_rdata_cycle: assert property (p_rdata_cycle)
    else $error("threshold read back wrong");

endmodule : line_rx_alarm_interrupt
`default_nettype wire

/* File: verilog/line_rx_alarm_pkg.sv */
// constants, register map and field layout of the receive alarm block
// assumes a single 250 MHz core clock shared by every design module
package line_rx_alarm_pkg;

  // ----------------------------------------------------------------------
  // alarm vector layout
  // ----------------------------------------------------------------------
  localparam int NUM_ALARMS = 6;
  localparam int ALM_CABLE = 0;
  localparam int ALM_LOS = 1;
  localparam int ALM_ONES = 2;
  localparam int ALM_PRBS = 3;
  localparam int ALM_LOOP = 4;
  localparam int ALM_FIFO = 5;
  typedef logic [NUM_ALARMS-1:0] alarm_vec_t;
  typedef logic [6:0] db_t;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam logic [9:0] OFS_GLOBAL_CTRL = 10'h000;
  localparam logic [9:0] OFS_CABLE_THRESH = 10'h004;
  localparam logic [9:0] OFS_LOS_COUNT = 10'h008;
  localparam logic [9:0] OFS_CHAN_PENDING = 10'h00C;
  localparam logic [1:0] CH_BASE_SEL = 2'h1;
  localparam logic [3:0] CH_OFS_CTRL = 4'h0;
  localparam logic [3:0] CH_OFS_ENABLE = 4'h4;
  localparam logic [3:0] CH_OFS_STATUS = 4'h8;
  localparam logic [3:0] CH_OFS_CLEAR = 4'hC;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int GCTL_IRQ_EN = 0;
  localparam int GCTL_EDGE = 1;
  localparam int GCTL_SLICE_LSB = 2;
  localparam int LOSC_E1_LSB = 8;
  localparam int CHCTL_E1 = 2;
  localparam int CHCTL_EXT = 3;
  localparam int CHCTL_LIVE_LSB = 16;
  localparam int CHCTL_CLV_LSB = 24;

  // ----------------------------------------------------------------------
  // reset values and detection figures
  // ----------------------------------------------------------------------
  localparam logic [7:0] T1_LOS_RESET = 8'hAF;
  localparam logic [7:0] E1_LOS_RESET = 8'hFF;
  localparam logic [7:0] E1_LOS_MIN = 8'h0A;
  localparam logic [12:0] EXT_LOS_ZEROS = 13'h1000;
  localparam db_t ANALOG_MARGIN_DB = 7'h09;
  localparam db_t ANALOG_HYST_DB = 7'h03;
  localparam db_t GAIN_DB [0:3] = '{7'h0F, 7'h1D, 7'h24, 7'h2D};
  localparam logic [6:0] SLICER_PCT [0:3] = '{7'h32, 7'h2D, 7'h37, 7'h44};

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_KHZ = 250000;
  localparam int MASTER_KHZ = 1544;
  localparam int MASTER_HALF_CYC = CLK_KHZ / (2 * MASTER_KHZ);

endpackage : line_rx_alarm_pkg

/* File: verilog/rx_channel_los.sv */
// one receive channel: edge pick, zero-run and amplitude loss detection
// assumes line clock and mark are asynchronous pins; attenuation is on
// the core clock
`timescale 1ns/1ps
`default_nettype none
module rx_channel_los
  import line_rx_alarm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  chan_if.unit cfg,
  input wire logic line_clk_pin,
  input wire logic line_mark_pin,
  input wire logic [5:0] attenuation_db,
  input wire logic master_tick,
  output logic rec_clk,
  output logic rec_data
);
  logic clk_s1_q, clk_s2_q, clk_s3_q, mark_s1_q, mark_s2_q;
  logic [12:0] zero_cnt_q, zero_cnt_d;
  logic dlos_q, dlos_d, alos_q, alos_d, mclk_q, mclk_d;
  logic rclk_q, rclk_d, rdata_q, rdata_d, edge_hit;
  logic [12:0] thresh;
  db_t limit, atten;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    edge_hit = cfg.edge_sel ? (clk_s3_q & ~clk_s2_q) : (clk_s2_q & ~clk_s3_q);
    if (cfg.ext_los) begin
      thresh = EXT_LOS_ZEROS;
    end else if (cfg.e1_mode) begin
      thresh = {5'h00, (cfg.e1_count < E1_LOS_MIN) ? E1_LOS_MIN : cfg.e1_count};
    end else begin
      thresh = {5'h00, cfg.t1_count};
    end
    zero_cnt_d = zero_cnt_q;
    if (edge_hit) begin
      if (mark_s2_q) begin
        zero_cnt_d = 13'h0000;
      end else if (zero_cnt_q != 13'h1FFF) begin
        zero_cnt_d = zero_cnt_q + 13'h0001;
      end
    end
    dlos_d = (zero_cnt_q >= thresh);
    limit = GAIN_DB[cfg.gain_sel] + ANALOG_MARGIN_DB;
    atten = {1'b0, attenuation_db};
    alos_d = alos_q;
    if (atten >= limit) begin
      alos_d = 1'b1;
    end else if (atten + ANALOG_HYST_DB <= limit) begin
      alos_d = 1'b0;
    end
    mclk_d = master_tick ? ~mclk_q : mclk_q;
    rclk_d = (dlos_q | alos_q) ? mclk_q : clk_s2_q;
    rdata_d = edge_hit ? mark_s2_q : rdata_q;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      mark_s1_q <= 1'b0;
      mark_s2_q <= 1'b0;
      zero_cnt_q <= 13'h0000;
      dlos_q <= 1'b0;
      alos_q <= 1'b0;
      mclk_q <= 1'b0;
      rclk_q <= 1'b0;
      rdata_q <= 1'b0;
    end else begin
      clk_s1_q <= line_clk_pin;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      mark_s1_q <= line_mark_pin;
      mark_s2_q <= mark_s1_q;
      zero_cnt_q <= zero_cnt_d;
      dlos_q <= dlos_d;
      alos_q <= alos_d;
      mclk_q <= mclk_d;
      rclk_q <= rclk_d;
      rdata_q <= rdata_d;
    end
  end

  assign cfg.digital_los = dlos_q;
  assign cfg.analog_los = alos_q;
  assign rec_clk = rclk_q;
  assign rec_data = rdata_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_ext_run;
    @(posedge ref_clk) disable iff (reset)
    cfg.ext_los && zero_cnt_q == 13'h1000 |=> dlos_q;
  endproperty
  a_ext_run: assert property (p_ext_run)
    else $error("extended run did not declare loss");

  property p_e1_floor;
    @(posedge ref_clk) disable iff (reset)
    cfg.e1_mode && !cfg.ext_los && zero_cnt_q < {5'h00, E1_LOS_MIN} |=> !dlos_q;
  endproperty
  a_e1_floor: assert property (p_e1_floor)
    else $error("e1 loss declared below ten intervals");

  property p_analog_declare;
    @(posedge ref_clk) disable iff (reset)
    atten >= limit |=> alos_q;
  endproperty
  a_analog_declare: assert property (p_analog_declare)
    else $error("analog loss not declared");

  property p_free_run;
    @(posedge ref_clk) disable iff (reset)
    (dlos_q || alos_q) |=> rclk_q == $past(mclk_q);
  endproperty
  a_free_run: assert property (p_free_run)
    else $error("recovered clock not on master during loss");

endmodule : rx_channel_los
`default_nettype wire
